// *** hdl/uvp_ctrl.sv ***
// Host-side programmer controller driving the pins of a 2K x 8 UV EPROM.
`timescale 1ns/1ns
module uvp_ctrl #(
  parameter int PW_CYCLES  = uvp_pkg::PW_CYC,
  parameter int NUM_UNITS  = 1
) (
  input  wire logic                     mclk,
  input  wire logic                     rst_b,
  input  wire logic                     req_valid,
  output logic                          req_ready,
  input  wire uvp_pkg::uvp_cmd_t        req_cmd,
  input  wire logic [uvp_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [uvp_pkg::DATA_W-1:0] req_data,
  input  wire logic [NUM_UNITS-1:0]     req_unit_sel,
  output logic                          rsp_valid,
  output logic [uvp_pkg::DATA_W-1:0]    rsp_data,
  output logic                          rsp_fail,
  output logic [uvp_pkg::ADDR_W-1:0]    address_inputs,
  output logic [NUM_UNITS-1:0]          chip_enable_program_pulse,
  output logic                          output_enable_b,
  output logic                          vpp_high,
  output logic [uvp_pkg::DATA_W-1:0]    data_pins_o,
  output logic                          data_pins_oe,
  input  wire logic [uvp_pkg::DATA_W-1:0] data_pins_i
);
  import uvp_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_ACCESS, ST_FLOAT
  } uvp_state_t;

  uvp_state_t          state_r, state_nxt;
  logic [CNT_W-1:0]    cnt_r, cnt_nxt;
  uvp_cmd_t            cmd_r, cmd_nxt;
  logic [ADDR_W-1:0]   addr_r, addr_nxt;
  logic [DATA_W-1:0]   wdata_r, wdata_nxt;
  logic [NUM_UNITS-1:0] sel_r, sel_nxt;
  logic [NUM_UNITS-1:0] ce_r, ce_nxt;
  logic                oe_b_r, oe_b_nxt;
  logic                vpp_r, vpp_nxt;
  logic                drv_r, drv_nxt;
  logic                rv_r, rv_nxt;
  logic [DATA_W-1:0]   rdata_r, rdata_nxt;
  logic                fail_r, fail_nxt;
  logic [DATA_W-1:0]   pins_sync;

  localparam logic [CNT_W-1:0] SETUP_N = CNT_W'(SETUP_CYC);
  localparam logic [CNT_W-1:0] HOLD_N  = CNT_W'(HOLD_CYC);
  // Two extra cycles cover the synchroniser on the returned data.
  localparam logic [CNT_W-1:0] ACC_N   = CNT_W'(ACC_CYC + 2);
  localparam logic [CNT_W-1:0] DF_N    = CNT_W'(DF_CYC);
  localparam logic [CNT_W-1:0] PW_N    = CNT_W'(PW_CYCLES);

  uvp_sync u_sync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .d_in  (data_pins_i),
    .d_out (pins_sync)
  );

  function automatic logic cnt_done(input logic [CNT_W-1:0] c);
    return c <= CNT_W'(1);
  endfunction : cnt_done

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    cmd_nxt   = cmd_r;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    sel_nxt   = sel_r;
    ce_nxt    = ce_r;
    oe_b_nxt  = oe_b_r;
    vpp_nxt   = vpp_r;
    drv_nxt   = drv_r;
    rv_nxt    = 1'b0;
    rdata_nxt = rdata_r;
    fail_nxt  = fail_r;
    case (state_r)
      ST_IDLE: begin
        // Idle parks every unit in standby with outputs disabled.
        ce_nxt   = '1;
        oe_b_nxt = 1'b1;
        vpp_nxt  = 1'b0;
        drv_nxt  = 1'b0;
        if (req_valid) begin
          // Any address order is accepted, each request stands alone.
          cmd_nxt   = req_cmd;
          addr_nxt  = req_addr;
          wdata_nxt = req_data;
          sel_nxt   = req_unit_sel;
          fail_nxt  = 1'b0;
          if (req_cmd == UVP_CMD_READ) begin
            ce_nxt    = '0;
            oe_b_nxt  = 1'b0;
            cnt_nxt   = ACC_N;
            state_nxt = ST_ACCESS;
          end else begin
            // Program set-up: enable low, outputs off, high supply.
            ce_nxt    = '0;
            oe_b_nxt  = 1'b1;
            vpp_nxt   = 1'b1;
            drv_nxt   = 1'b1;
            cnt_nxt   = SETUP_N;
            state_nxt = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        cnt_nxt = cnt_r - CNT_W'(1);
        if (cnt_done(cnt_r)) begin
          // Only selected units see the pulse; others stay inhibited.
          ce_nxt    = sel_r;
          cnt_nxt   = PW_N;
          state_nxt = ST_PULSE;
        end
      end
      ST_PULSE: begin
        cnt_nxt = cnt_r - CNT_W'(1);
        if (cnt_done(cnt_r)) begin
          ce_nxt    = '0;
          cnt_nxt   = HOLD_N;
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        cnt_nxt = cnt_r - CNT_W'(1);
        if (cnt_done(cnt_r)) begin
          drv_nxt = 1'b0;
          if (cmd_r == UVP_CMD_PROGVER) begin
            // Verify reads the byte back with the supply still high.
            oe_b_nxt  = 1'b0;
            cnt_nxt   = ACC_N;
            state_nxt = ST_ACCESS;
          end else begin
            // A single pulse is issued; the user may repeat the request.
            rv_nxt    = 1'b1;
            // Supply drops before the enable rises, else the rise programs.
            vpp_nxt   = 1'b0;
            cnt_nxt   = DF_N;
            state_nxt = ST_FLOAT;
          end
        end
      end
      ST_ACCESS: begin
        cnt_nxt = cnt_r - CNT_W'(1);
        if (cnt_done(cnt_r)) begin
          rdata_nxt = pins_sync;
          // Any bit that reads back different from the written byte flags a fault.
          if (cmd_r == UVP_CMD_PROGVER) begin
            fail_nxt = (pins_sync != wdata_r);
          end
          rv_nxt    = 1'b1;
          oe_b_nxt  = 1'b1;
          // Enable stays low one more cycle so the supply is low first.
          vpp_nxt   = 1'b0;
          cnt_nxt   = DF_N;
          state_nxt = ST_FLOAT;
        end
      end
      ST_FLOAT: begin
        // Wait for the device to release the pins before a new request.
        ce_nxt  = '1;
        cnt_nxt = cnt_r - CNT_W'(1);
        if (cnt_done(cnt_r)) begin
          vpp_nxt   = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      cmd_r   <= UVP_CMD_READ;
      addr_r  <= '0;
      wdata_r <= ERASED_BYTE;
      sel_r   <= '0;
      ce_r    <= '1;
      oe_b_r  <= 1'b1;
      vpp_r   <= 1'b0;
      drv_r   <= 1'b0;
      rv_r    <= 1'b0;
      rdata_r <= '0;
      fail_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      cmd_r   <= cmd_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      sel_r   <= sel_nxt;
      ce_r    <= ce_nxt;
      oe_b_r  <= oe_b_nxt;
      vpp_r   <= vpp_nxt;
      drv_r   <= drv_nxt;
      rv_r    <= rv_nxt;
      rdata_r <= rdata_nxt;
      fail_r  <= fail_nxt;
    end
  end

  assign req_ready                 = (state_r == ST_IDLE);
  assign rsp_valid                 = rv_r;
  assign rsp_data                  = rdata_r;
  assign rsp_fail                  = fail_r;
  assign address_inputs            = addr_r;
  assign chip_enable_program_pulse = ce_r;
  assign output_enable_b           = oe_b_r;
  assign vpp_high                  = vpp_r;
  assign data_pins_o               = wdata_r;
  assign data_pins_oe              = drv_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  int unsigned hi_cnt;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) hi_cnt <= 0;
    else if (state_r == ST_PULSE) hi_cnt <= hi_cnt + 1;
    else hi_cnt <= 0;
  end

  a_pulse_max_width: assert property (@(posedge mclk) disable iff (!rst_b)
    hi_cnt <= PW_CYCLES) else $error("program pulse too long");
  a_pulse_len_exact: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(state_r == ST_PULSE) |-> hi_cnt == PW_CYCLES)
    else $error("program pulse length wrong");
  a_drive_oe_high: assert property (@(posedge mclk) disable iff (!rst_b)
    data_pins_oe |-> output_enable_b) else $error("bus contention");
  a_vpp_in_prog: assert property (@(posedge mclk) disable iff (!rst_b)
    data_pins_oe |-> vpp_high) else $error("supply low in program");
  a_idle_standby: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == ST_IDLE |-> &chip_enable_program_pulse && !vpp_high)
    else $error("idle not standby");
  a_unsel_no_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == ST_PULSE |-> chip_enable_program_pulse == sel_r)
    else $error("pulse to wrong unit");
  a_read_enables: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == ST_ACCESS |-> !output_enable_b && !data_pins_oe)
    else $error("read enables wrong");
  a_verify_flag: assert property (@(posedge mclk) disable iff (!rst_b)
    rsp_valid && cmd_r == UVP_CMD_PROGVER |->
    rsp_fail == (rsp_data != wdata_r))
    else $error("verify flag wrong");
  a_enable_low_supply: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r != ST_PULSE && |chip_enable_program_pulse |-> !vpp_high)
    else $error("enable high with program supply");
  a_setup_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(state_r == ST_PULSE) |-> $past(data_pins_oe, 2))
    else $error("no data set-up");

  c_program: cover property (@(posedge mclk) disable iff (!rst_b)
    rsp_valid && cmd_r == UVP_CMD_PROGRAM);
  c_verify_fail: cover property (@(posedge mclk) disable iff (!rst_b)
    rsp_valid && rsp_fail);
  c_read: cover property (@(posedge mclk) disable iff (!rst_b)
    rsp_valid && cmd_r == UVP_CMD_READ);
endmodule : uvp_ctrl

// *** hdl/uvp_pkg.sv ***
// Package of pin timing constants and command codes for the EPROM programmer.
package uvp_pkg;

  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int ADDR_W      = 11;
  localparam int DATA_W      = 8;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_NS      = 10;
  localparam int PW_MIN_MS   = 45;
  localparam int PW_NOM_MS   = 50;
  localparam int PW_MAX_MS   = 55;
  localparam int SETUP_US    = 2;
  localparam int HOLD_US     = 2;
  localparam int ACC_NS      = 450;
  localparam int DF_NS       = 100;
  // Nominal pulse sits inside the 45 to 55 ms window.
  localparam int PW_CYC      = PW_NOM_MS * 1000000 / CLK_NS;
  localparam int PW_MIN_CYC  = (PW_MIN_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int PW_MAX_CYC  = PW_MAX_MS * 1000000 / CLK_NS;
  localparam int SETUP_CYC   = (SETUP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC    = (HOLD_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC     = (ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int DF_CYC      = (DF_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W       = 24;

  // ****************************************************************
  // Commands
  // ****************************************************************
  typedef enum logic [1:0] {
    UVP_CMD_READ    = 2'h0,
    UVP_CMD_PROGRAM = 2'h1,
    UVP_CMD_PROGVER = 2'h2
  } uvp_cmd_t;

endpackage : uvp_pkg

// *** hdl/uvp_sync.sv ***
// Two flip-flop synchroniser for the data pins read back from the device.
`timescale 1ns/1ns
module uvp_sync (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [7:0] d_in,
  output logic      [7:0] d_out
);
  logic [7:0] meta_r;
  logic [7:0] sync_r;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 8'h00;
      sync_r <= 8'h00;
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign d_out = sync_r;
endmodule : uvp_sync

// *** dv/uvp_dev_model.sv ***
// Behavioural model of one UV EPROM unit seen from the programmer pins.
`timescale 1ns/1ns
module uvp_dev_model #(
  parameter int PW_NS = 500
) (
  input  wire logic        ce,
  input  wire logic        oe_b,
  input  wire logic        vpp,
  input  wire logic [10:0] addr,
  input  wire logic [7:0]  d,
  output logic             en,
  output logic      [7:0]  q,
  output logic             viol
);
  logic [7:0] mem [2048];
  logic       armed;
  realtime    t_rise;
  initial begin
    viol = 1'b0;
    armed = 1'b0;
    t_rise = 0;
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  // Data appears after the normal access delay, floats at once on exit.
  assign #(300,0) en = !ce && !oe_b;
  assign q = mem[addr];
  // Only a rise with the high supply and outputs off is a program pulse.
  always @(posedge ce) begin
    t_rise = $realtime;
    armed = vpp === 1'b1 && oe_b === 1'b1;
  end
  always @(negedge ce) begin
    if (armed) begin
      if ($realtime - t_rise < PW_NS * 0.9 || $realtime - t_rise > PW_NS * 1.1)
        viol = 1'b1;
      mem[addr] = mem[addr] & d;
    end
    armed = 1'b0;
  end
endmodule : uvp_dev_model

// *** dv/tb_top.sv ***
// Self-checking bench for the programmer with two ganged EPROM units.
`timescale 1ns/1ns
module tb_top;
  import uvp_pkg::*;
  localparam int PW = 50;
  typedef struct { logic ck; logic [7:0] d; logic f; } uvp_exp_t;
  logic        mclk, rst_b, req_valid, req_ready, rsp_valid, rsp_fail;
  logic        output_enable_b, vpp_high, data_pins_oe;
  uvp_cmd_t    req_cmd;
  logic [10:0] req_addr, address_inputs, a0;
  logic [7:0]  req_data, rsp_data, data_pins_o, data_pins_i, q0, q1, flt, d0;
  logic [1:0]  req_unit_sel, chip_enable_program_pulse, en, viol;
  logic [7:0]  img [2][2048];
  logic [10:0] used [$];
  uvp_exp_t    q [$];
  uvp_exp_t    mx;
  int          num_errors, total_checks, seed;

  uvp_ctrl #(.PW_CYCLES(PW), .NUM_UNITS(2)) u_dut (
    .mclk(mclk), .rst_b(rst_b), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr),
    .req_data(req_data), .req_unit_sel(req_unit_sel),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_fail(rsp_fail),
    .address_inputs(address_inputs),
    .chip_enable_program_pulse(chip_enable_program_pulse),
    .output_enable_b(output_enable_b), .vpp_high(vpp_high),
    .data_pins_o(data_pins_o), .data_pins_oe(data_pins_oe),
    .data_pins_i(data_pins_i));
  uvp_dev_model #(.PW_NS(PW * 10)) u_dev0 (
    .ce(chip_enable_program_pulse[0]), .oe_b(output_enable_b),
    .vpp(vpp_high), .addr(address_inputs), .d(data_pins_i),
    .en(en[0]), .q(q0), .viol(viol[0]));
  uvp_dev_model #(.PW_NS(PW * 10)) u_dev1 (
    .ce(chip_enable_program_pulse[1]), .oe_b(output_enable_b),
    .vpp(vpp_high), .addr(address_inputs), .d(data_pins_i),
    .en(en[1]), .q(q1), .viol(viol[1]));

  // ****************************************************************
  // Shared data bus
  // ****************************************************************
  // Undriven pins show a changing pattern rather than a stale byte.
  assign data_pins_i = data_pins_oe ? data_pins_o : (en != 2'b00) ?
    ((en[0] ? q0 : 8'hFF) & (en[1] ? q1 : 8'hFF)) : flt;
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial flt = 8'h00;
  always @(posedge mclk) flt <= flt + 8'h35;

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic idle(input bit empty);
    int n;
    n = 0;
    while (((empty && q.size() != 0) || req_ready !== 1'b1) && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 5000) begin
      chk(8'h00, 8'h01);
      finish_test();
    end
  endtask : idle

  task automatic op(input logic [1:0] c, input logic [10:0] a,
                    input logic [7:0] d, input logic [1:0] s);
    uvp_exp_t x;
    idle(1'b0);
    if (c != 2'h0) begin
      for (int u = 0; u < 2; u++) if (s[u]) img[u][a] &= d;
    end
    x.ck = c == 2'h0 || c == 2'h2;
    x.d = img[0][a] & img[1][a];
    x.f = c == 2'h2 && x.d !== d;
    q.push_back(x);
    used.push_back(a);
    req_cmd = uvp_cmd_t'(c);
    req_addr = a;
    req_data = d;
    req_unit_sel = s;
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
  endtask : op

  // ****************************************************************
  // Response and bus watcher
  // ****************************************************************
  always @(negedge mclk) begin
    if (data_pins_oe === 1'b1) chk(8'(en), 8'h00);
    if (rsp_valid === 1'b1) begin
      if (q.size() == 0) begin
        chk(8'h00, 8'h01);
      end else begin
        mx = q.pop_front();
        if (mx.ck) chk(rsp_data, mx.d);
        chk(8'(rsp_fail), 8'(mx.f));
      end
    end
  end

  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req_cmd = UVP_CMD_READ;
    req_addr = 11'h000;
    req_data = 8'h00;
    req_unit_sel = 2'h0;
    foreach (img[u, i]) img[u][i] = 8'hFF;
    seed = $urandom(32'hD74ABC23);
    repeat (10) @(negedge mclk);
    chk(8'(chip_enable_program_pulse), 8'h03);
    chk(8'({output_enable_b, vpp_high, data_pins_oe}), 8'h04);
    rst_b = 1'b1;
    a0 = 11'($urandom);
    d0 = 8'($urandom);
    op(2'h0, a0, 8'h00, 2'b11);
    op(2'h2, a0, d0, 2'b01);
    idle(1'b1);
    chk(u_dev1.mem[a0], 8'hFF);
    chk(u_dev0.mem[a0], d0);
    $display("Test single unit program done");
    op(2'h2, a0, 8'($urandom), 2'b01);
    for (int i = 0; i < 16; i++) begin
      op(2'(i), (i % 3 == 0) ? a0 + 11'(i) : 11'($urandom), 8'($urandom),
         2'($urandom_range(1, 3)));
    end
    $display("Test mixed commands done");
    for (int i = used.size() - 1; i >= 0; i--) op(2'h0, used[i], 8'h00, 2'b11);
    idle(1'b1);
    chk(8'(viol), 8'h00);
    $display("Test read back done");
    finish_test();
  end
endmodule : tb_top
